// >>> core/sbc_regs.vh
`ifndef SBC_REGS_VH
`define SBC_REGS_VH

// ****************************************
// register addresses
// ****************************************
`define SBC_CN_ADDR 8'hC0
`define SBC_CF_ADDR 8'hC1
`define SBC_ADM_ADDR 8'hD6

// ****************************************
// serial_bus_config fields
// ****************************************
`define SBC_CF_ON 7
`define SBC_CF_MUTE 6
`define SBC_CF_BUSY 5
`define SBC_CF_EXT 4
`define SBC_CF_TOE 3
`define SBC_CF_FTE 2
`define SBC_CF_CS_HI 1
`define SBC_CF_CS_LO 0
`define SBC_CF_RST 8'h00

// ****************************************
// serial_bus_control fields
// ****************************************
`define SBC_CN_MASTER 7
`define SBC_CN_TXM 6
`define SBC_CN_BEGIN 5
`define SBC_CN_END 4
`define SBC_CN_ACK_REQUEST 3
`define SBC_CN_ARBL 2
`define SBC_CN_ACK 1
`define SBC_CN_SI 0
`define SBC_CN_RST 8'h00

// ****************************************
// slave_match_reg fields
// ****************************************
`define SBC_ADM_AUTOACK 0
`define SBC_ADM_RST 8'h00

// ****************************************
// timing in system clocks and source ticks
// ****************************************
`define SBC_HOLD_NORM 4'h3
`define SBC_HOLD_EXT 4'hC
`define SBC_SU_NORM 4'h1
`define SBC_SU_EXT 4'hB
`define SBC_FREE_TICKS 4'hA

`endif

// >>> core/sbc_sync.v
`timescale 1ns/1ps
`default_nettype none
module sbc_sync #(
  parameter W = 2
) (
  input wire clk,
  input wire rst_b,
  input wire [W-1:0] din,
  output reg [W-1:0] lvl_q,
  output wire [W-1:0] rise,
  output wire [W-1:0] fall
);
  reg [W-1:0] meta_q;
  reg [W-1:0] prev_q;

  // idle bus level is high, so reset there
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= {W{1'b1}};
      lvl_q <= {W{1'b1}};
      prev_q <= {W{1'b1}};
    end else begin
      meta_q <= din;
      lvl_q <= meta_q;
      prev_q <= lvl_q;
    end
  end

  assign rise = lvl_q & ~prev_q;
  assign fall = ~lvl_q & prev_q;
endmodule
`default_nettype wire

// >>> core/sbc_rate.v
`timescale 1ns/1ps
`default_nettype none
`include "sbc_regs.vh"
module sbc_rate (
  input wire clk,
  input wire rst_b,
  input wire [1:0] sel,
  input wire [3:0] ovf,
  input wire bus_high,
  input wire free_en,
  output reg tick_q,
  output reg free_q
);
  reg [3:0] cnt_q;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_q <= 1'b0;
      free_q <= 1'b0;
      cnt_q <= 4'h0;
    end else begin
      tick_q <= ovf[sel];
      free_q <= 1'b0;
      if (!bus_high || !free_en) begin
        cnt_q <= 4'h0;
      end else if (tick_q && cnt_q == `SBC_FREE_TICKS) begin
        // saturate past the limit so free fires once per idle spell
        free_q <= 1'b1;
        cnt_q <= cnt_q + 4'h1;
      end else if (tick_q && cnt_q < `SBC_FREE_TICKS) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> core/sbc_core.v
`timescale 1ns/1ps
`default_nettype none
`include "sbc_regs.vh"
module sbc_core (
  input wire clk,
  input wire rst_b,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata_q,
  input wire scl_in,
  output wire scl_out,
  output reg scl_oe_q,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe_q,
  input wire t0_ovf,
  input wire t1_ovf,
  input wire t2h_ovf,
  input wire t2l_ovf,
  input wire tmr3_split,
  output reg tmr3_hi_reload_q,
  output reg tmr3_lo_reload_q,
  input wire [7:0] tx_byte,
  output reg [7:0] rx_byte_q,
  input wire addr_hit
);
  // ****************************************
  // states
  // ****************************************
  localparam S_IDLE = 5'h01;
  localparam S_GSTA = 5'h02;
  localparam S_XFER = 5'h04;
  localparam S_GSTO = 5'h08;
  localparam S_GREP = 5'h10;

  function is_at;
    input [7:0] a;
    input [7:0] off;
    begin
      is_at = (a == off);
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  reg on_q, mute_q, busy_q, ext_q, toe_q, fte_q, autoack_q;
  reg [1:0] cs_q;
  reg master_q, txm_q, begin_q, end_q, ack_request_q, arbl_q, ack_q, si_q;
  reg [4:0] st_q;
  reg [1:0] gstep_q;
  reg [3:0] bit_cnt_q, hold_q, su_q;
  reg [7:0] shf_q;
  reg byte0_q, rw_q, active_q, ign_q, mute_eff_q, scl_low_q;
  reg sda_drv_q, tick_seen_q;
  // only a software write asks for a start, never a detected one
  reg start_req_q;

  wire [1:0] lvl, rise, fall;
  wire tick, free;
  wire scl_s = lvl[1];
  wire sda_s = lvl[0];
  wire start_det = fall[0] & scl_s;
  wire stop_det = rise[0] & scl_s;

  sbc_sync #(.W(2)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .din({scl_in, sda_in}),
    .lvl_q(lvl),
    .rise(rise),
    .fall(fall)
  );

  sbc_rate u_rate (
    .clk(clk),
    .rst_b(rst_b),
    .sel(cs_q),
    .ovf({t2l_ovf, t2h_ovf, t1_ovf, t0_ovf}),
    .bus_high(scl_s & sda_s),
    .free_en(fte_q & on_q),
    .tick_q(tick),
    .free_q(free)
  );

  wire wr_cf = sfr_wr & is_at(sfr_addr, `SBC_CF_ADDR);
  wire wr_cn = sfr_wr & is_at(sfr_addr, `SBC_CN_ADDR);
  wire wr_adm = sfr_wr & is_at(sfr_addr, `SBC_ADM_ADDR);
  wire si_clr = wr_cn & si_q & ~sfr_wdata[`SBC_CN_SI];
  wire begin_n = wr_cn ? sfr_wdata[`SBC_CN_BEGIN] : begin_q;
  wire end_n = wr_cn ? sfr_wdata[`SBC_CN_END] : end_q;
  wire [3:0] hold_n = ext_q ? `SBC_HOLD_EXT : `SBC_HOLD_NORM;
  wire [3:0] su_n = ext_q ? `SBC_SU_EXT : `SBC_SU_NORM;

  // ****************************************
  // outgoing sda value
  // ****************************************
  wire addr_lsn = byte0_q & ~master_q & ~ign_q;
  // muted slaves always nack the address
  wire ack_bit = (byte0_q & ~master_q) ?
    ((autoack_q ? addr_hit : ack_q) & ~mute_eff_q) :
    ack_q;
  wire ack_drv = ~txm_q & (active_q | addr_lsn) & ack_bit;
  wire want = (bit_cnt_q == 4'h8) ? ~ack_drv :
    ((txm_q & active_q) ? shf_q[7] : 1'b1);
  wire frame_end = master_q & (end_n | begin_n);

  // ****************************************
  // pins and timer reload
  // ****************************************
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      tmr3_hi_reload_q <= 1'b0;
      tmr3_lo_reload_q <= 1'b0;
    end else begin
      scl_oe_q <= on_q & (scl_low_q | si_q);
      sda_oe_q <= on_q & ~sda_drv_q;
      tmr3_hi_reload_q <= toe_q & scl_s;
      tmr3_lo_reload_q <= toe_q & scl_s & ~tmr3_split;
    end
  end

  // ****************************************
  // register read
  // ****************************************
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata_q <= 8'h00;
    end else if (is_at(sfr_addr, `SBC_CF_ADDR)) begin
      sfr_rdata_q <= {on_q, mute_q, busy_q, ext_q, toe_q, fte_q, cs_q};
    end else if (is_at(sfr_addr, `SBC_CN_ADDR)) begin
      sfr_rdata_q <= {master_q, txm_q, begin_q, end_q,
        ack_request_q, arbl_q, ack_q, si_q};
    end else if (is_at(sfr_addr, `SBC_ADM_ADDR)) begin
      sfr_rdata_q <= {7'h00, autoack_q};
    end else begin
      sfr_rdata_q <= 8'h00;
    end
  end

  // ****************************************
  // control engine
  // ****************************************
  // software writes come first so hardware sets below win a tie
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {on_q, mute_q, ext_q, toe_q, fte_q, cs_q} <= 7'h00;
      autoack_q <= 1'b0;
      {master_q, txm_q, begin_q, end_q} <= 4'h0;
      {ack_request_q, arbl_q, ack_q, si_q} <= 4'h0;
      busy_q <= 1'b0;
      st_q <= S_IDLE;
      gstep_q <= 2'h0;
      bit_cnt_q <= 4'h0;
      hold_q <= 4'h0;
      su_q <= 4'h0;
      shf_q <= 8'h00;
      rx_byte_q <= 8'h00;
      {byte0_q, rw_q, active_q, ign_q, mute_eff_q} <= 5'h00;
      scl_low_q <= 1'b0;
      sda_drv_q <= 1'b1;
      tick_seen_q <= 1'b0;
      start_req_q <= 1'b0;
    end else begin
      if (wr_cf) begin
        on_q <= sfr_wdata[`SBC_CF_ON];
        mute_q <= sfr_wdata[`SBC_CF_MUTE];
        ext_q <= sfr_wdata[`SBC_CF_EXT];
        toe_q <= sfr_wdata[`SBC_CF_TOE];
        fte_q <= sfr_wdata[`SBC_CF_FTE];
        cs_q <= sfr_wdata[`SBC_CF_CS_HI:`SBC_CF_CS_LO];
      end
      if (wr_adm) begin
        autoack_q <= sfr_wdata[`SBC_ADM_AUTOACK];
      end
      if (wr_cn) begin
        begin_q <= sfr_wdata[`SBC_CN_BEGIN];
        start_req_q <= sfr_wdata[`SBC_CN_BEGIN];
        end_q <= sfr_wdata[`SBC_CN_END];
        ack_q <= sfr_wdata[`SBC_CN_ACK];
        si_q <= sfr_wdata[`SBC_CN_SI];
      end
      if (si_clr) begin
        arbl_q <= 1'b0;
        ack_request_q <= 1'b0;
        if (txm_q) begin
          shf_q <= tx_byte;
        end
      end
      if (scl_rise_or_fall(rise[1], fall[1])) begin
        tick_seen_q <= 1'b0;
      end else if (tick) begin
        tick_seen_q <= 1'b1;
      end
      if (fall[1]) begin
        hold_q <= hold_n;
      end else if (hold_q != 4'h0) begin
        hold_q <= hold_q - 4'h1;
      end
      if (!on_q) begin
        // disabling is the software escape from a stuck bus
        busy_q <= 1'b0;
        st_q <= S_IDLE;
        master_q <= 1'b0;
        {active_q, ign_q, scl_low_q} <= 3'h0;
        sda_drv_q <= 1'b1;
        bit_cnt_q <= 4'h0;
      end else begin
        if (start_det) begin
          busy_q <= 1'b1;
          {bit_cnt_q, byte0_q, ign_q} <= {4'h0, 1'b1, 1'b0};
          mute_eff_q <= mute_q;
          txm_q <= 1'b0;
          if (!master_q) begin
            begin_q <= 1'b1;
            active_q <= 1'b0;
          end
          if (st_q == S_IDLE) begin
            st_q <= S_XFER;
          end
        end
        if ((stop_det || free) && !master_q) begin
          busy_q <= 1'b0;
          st_q <= S_IDLE;
          active_q <= 1'b0;
          if (stop_det && active_q) begin
            end_q <= 1'b1;
            si_q <= 1'b1;
          end
        end else if (stop_det || free) begin
          busy_q <= 1'b0;
        end
        case (st_q)
          S_IDLE: begin
            if (start_req_q && !busy_q && !si_q) begin
              sda_drv_q <= 1'b0;
              gstep_q <= 2'h0;
              st_q <= S_GSTA;
            end
          end
          S_GSTA: begin
            // two ticks give at least one whole source period
            if (tick && gstep_q == 2'h0) begin
              gstep_q <= 2'h1;
            end else if (tick) begin
              {scl_low_q, master_q, txm_q, active_q} <= 4'hF;
              si_q <= 1'b1;
              st_q <= S_XFER;
            end
          end
          S_GSTO, S_GREP: begin
            if (gstep_q == 2'h0 && !scl_s && hold_q == 4'h0) begin
              sda_drv_q <= (st_q == S_GREP);
              gstep_q <= 2'h1;
            end else if (gstep_q == 2'h1 && tick_seen_q) begin
              scl_low_q <= 1'b0;
              gstep_q <= 2'h2;
            end else if (gstep_q == 2'h2 && scl_s && tick_seen_q) begin
              gstep_q <= 2'h0;
              if (st_q == S_GSTO) begin
                sda_drv_q <= 1'b1;
                {master_q, active_q, end_q} <= 3'h0;
                st_q <= S_IDLE;
              end else begin
                sda_drv_q <= 1'b0;
                st_q <= S_GSTA;
              end
            end
          end
          S_XFER: begin
            if (!scl_s && hold_q == 4'h0 && sda_drv_q != want) begin
              sda_drv_q <= want;
              su_q <= su_n;
            end else if (su_q != 4'h0) begin
              su_q <= su_q - 4'h1;
            end
            if (master_q && scl_low_q && tick_seen_q && !si_q &&
                su_q == 4'h0 && hold_q == 4'h0 && sda_drv_q == want) begin
              scl_low_q <= 1'b0;
            end else if (master_q && !scl_low_q && scl_s && tick_seen_q) begin
              scl_low_q <= 1'b1;
            end
            if (rise[1] && bit_cnt_q < 4'h8) begin
              shf_q <= {shf_q[6:0], sda_s};
              bit_cnt_q <= bit_cnt_q + 4'h1;
              if (bit_cnt_q == 4'h7) begin
                rx_byte_q <= {shf_q[6:0], sda_s};
                if (byte0_q) begin
                  rw_q <= sda_s;
                end
              end
              if (active_q && txm_q && sda_drv_q && !sda_s) begin
                arbl_q <= 1'b1;
                si_q <= 1'b1;
                {master_q, active_q, scl_low_q} <= 3'h0;
                sda_drv_q <= 1'b1;
              end
            end else if (rise[1] && bit_cnt_q == 4'h8) begin
              bit_cnt_q <= 4'h9;
              if (active_q && txm_q) begin
                ack_q <= ~sda_s;
              end
              if (addr_lsn) begin
                active_q <= ~sda_drv_q;
                ign_q <= sda_drv_q;
              end
            end
            if (fall[1] && bit_cnt_q == 4'h8 && !txm_q && !autoack_q &&
                (active_q || (addr_lsn && !mute_eff_q))) begin
              si_q <= 1'b1;
              ack_request_q <= 1'b1;
              ack_q <= 1'b0;
            end
            if (fall[1] && bit_cnt_q == 4'h9) begin
              {bit_cnt_q, byte0_q} <= 5'h00;
              if (byte0_q) begin
                txm_q <= master_q ? ~rw_q : rw_q;
              end
              if (active_q && (txm_q || autoack_q)) begin
                si_q <= 1'b1;
              end else if (frame_end) begin
                gstep_q <= 2'h0;
                st_q <= end_n ? S_GSTO : S_GREP;
              end
            end
            if (si_clr && frame_end && bit_cnt_q == 4'h0 && !byte0_q) begin
              gstep_q <= 2'h0;
              st_q <= end_n ? S_GSTO : S_GREP;
            end
          end
          default: begin
            st_q <= S_IDLE;
          end
        endcase
      end
    end
  end

  function scl_rise_or_fall;
    input r;
    input f;
    begin
      scl_rise_or_fall = r | f;
    end
  endfunction
endmodule
`default_nettype wire

// >>> bench/sbc_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbc_regs.vh"
module sbc_core_sva (
  input wire clk,
  input wire rst_b,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata_q,
  input wire scl_in,
  input wire scl_out,
  input wire scl_oe_q,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_q,
  input wire t0_ovf,
  input wire t1_ovf,
  input wire t2h_ovf,
  input wire t2l_ovf,
  input wire tmr3_split,
  input wire tmr3_hi_reload_q,
  input wire tmr3_lo_reload_q,
  input wire [7:0] tx_byte,
  input wire [7:0] rx_byte_q,
  input wire addr_hit
);
  // ********
  // shadow of config writes
  // ********
  reg [7:0] cfg_q;
  reg [3:0] low_ticks_q;
  wire [3:0] ovf = {t2l_ovf, t2h_ovf, t1_ovf, t0_ovf};
  wire on = cfg_q[7];
  wire toe = cfg_q[3];
  // ticks counted from the pin, before the core sees them: lenient
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= 8'h00;
      low_ticks_q <= 4'h0;
    end else begin
      if (sfr_wr && sfr_addr == `SBC_CF_ADDR)
        cfg_q <= sfr_wdata;
      if (!scl_oe_q)
        low_ticks_q <= 4'h0;
      else if (ovf[cfg_q[1:0]] && low_ticks_q != 4'hF)
        low_ticks_q <= low_ticks_q + 4'h1;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // ********
  // properties
  // ********
  off_release_a:
    assert property (!on |=> !scl_oe_q && !sda_oe_q)
    else $error("pins driven while off");
  reload_hi_a:
    assert property ((on && toe && scl_in && !tmr3_split)[*6]
      |-> tmr3_hi_reload_q && tmr3_lo_reload_q)
    else $error("timer not reloaded while scl high");
  reload_split_a:
    assert property ((on && toe && scl_in && tmr3_split)[*6]
      |-> tmr3_hi_reload_q && !tmr3_lo_reload_q)
    else $error("split timer reload wrong");
  count_low_a:
    assert property ((on && toe && !scl_in)[*6]
      |-> !tmr3_hi_reload_q && !tmr3_lo_reload_q)
    else $error("timer held while scl low");
  cfg_read_a:
    assert property (sfr_addr == `SBC_CF_ADDR
      |=> (sfr_rdata_q & 8'hDF) == ($past(cfg_q) & 8'hDF))
    else $error("config readback wrong");
  stall_a:
    assert property ((on && $past(sfr_addr) == `SBC_CN_ADDR
      && sfr_rdata_q[0])[*3] |-> scl_oe_q)
    else $error("scl released while flag set");
  low_phase_a:
    assert property (on && $fell(scl_oe_q) |-> low_ticks_q != 4'h0)
    else $error("scl low phase too short");
  hold_a:
    assert property (on && $fell(scl_in) |=> $stable(sda_oe_q)[*3])
    else $error("sda hold too short");
  hold_ext_a:
    assert property (on && cfg_q[4] && $fell(scl_in)
      |=> $stable(sda_oe_q)[*8])
    else $error("extended sda hold too short");
  cover property ($rose(scl_oe_q));
  cover property (on && tmr3_split && tmr3_hi_reload_q);
  cover property (on && $fell(scl_oe_q));
endmodule
`default_nettype wire

// >>> bench/sbc_bus_peer.sv
`timescale 1ns/1ps
`default_nettype none
module sbc_bus_peer (
  input wire scl,
  input wire sda,
  input wire ack_en,
  input wire stretch,
  output logic scl_low,
  output logic sda_low,
  output logic [7:0] byte_q
);
  // ********
  // far slave: acks bytes, may stretch scl
  // ********
  int bits = 0;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    byte_q = 8'h00;
  end
  // the fall closing a start is not a bit
  always @(negedge sda) begin
    if (scl)
      bits = -1;
  end
  always @(posedge scl) begin
    if (bits < 8)
      byte_q = {byte_q[6:0], sda};
  end
  always @(negedge scl) begin
    bits = bits + 1;
    if (bits == 8)
      sda_low = ack_en;
    if (bits == 9) begin
      sda_low = 1'b0;
      bits = 0;
    end
    if (stretch) begin
      scl_low = 1'b1;
      #400 scl_low = 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> bench/sbc_core_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbc_regs.vh"
module sbc_core_test;
  // ********
  // stimulus and wiring
  // ********
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] tx_byte = 8'h00;
  logic [7:0] d = 8'h00;
  logic [4:0] cnt = 5'h00;
  logic [3:0] ovf = 4'h0;
  logic [1:0] osel = 2'h0;
  logic wrong = 1'b0;
  logic split = 1'b0;
  logic b_scl = 1'b0;
  logic b_sda = 1'b0;
  logic stretch = 1'b0;
  int num_errors = 0;
  int samples_checked = 0;
  wire [7:0] rdata;
  wire [7:0] pbyte;
  wire scl_oe, sda_oe, p_scl, p_sda, hi, lo;
  // open drain lines with pull-ups
  wire scl = !(scl_oe || p_scl || b_scl);
  wire sda = !(sda_oe || p_sda || b_sda);
  always #4 clk = ~clk;
  // one overflow every 20 clocks, 160 ns
  always @(posedge clk) begin
    cnt <= (cnt == 5'h13) ? 5'h00 : cnt + 5'h01;
    if (cnt != 5'h13)
      ovf <= 4'h0;
    else if (wrong)
      ovf <= ~(4'h1 << osel);
    else
      ovf <= 4'h1 << osel;
  end
  sbc_core i_sbc_core (.clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata_q(rdata),
    .scl_in(scl), .scl_out(), .scl_oe_q(scl_oe), .sda_in(sda),
    .sda_out(), .sda_oe_q(sda_oe), .t0_ovf(ovf[0]), .t1_ovf(ovf[1]),
    .t2h_ovf(ovf[2]), .t2l_ovf(ovf[3]), .tmr3_split(split),
    .tmr3_hi_reload_q(hi), .tmr3_lo_reload_q(lo), .tx_byte(tx_byte),
    .rx_byte_q(), .addr_hit(1'b0));
  sbc_bus_peer i_sbc_bus_peer (.scl(scl), .sda(sda), .ack_en(1'b1),
    .stretch(stretch), .scl_low(p_scl), .sda_low(p_sda), .byte_q(pbyte));
  // ********
  // shared tasks
  // ********
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wr <= 1'b1;
    sfr_wdata <= v;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    sfr_addr <= a;
    cyc(2);
    d = rdata;
  endtask
  // bounded wait on a register field
  task automatic poll(input logic [7:0] a, input logic [7:0] m,
      input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      rd(a);
      if ((d & m) === v)
        return;
    end
    chk(d & m, v);
    end_of_test();
  endtask
  task automatic reset_dut();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_regs();
    rd(`SBC_CF_ADDR);
    chk(d, 8'h00);
    rd(`SBC_CN_ADDR);
    chk(d, 8'h00);
    rd(`SBC_ADM_ADDR);
    chk(d, 8'h00);
    rd(8'h55);
    chk(d, 8'h00);
    wr(`SBC_CF_ADDR, 8'hFF);
    rd(`SBC_CF_ADDR);
    chk(d, 8'hDF);
    wr(`SBC_CN_ADDR, 8'hCC);
    rd(`SBC_CN_ADDR);
    chk(d, 8'h00);
    wr(`SBC_CF_ADDR, 8'h00);
    $display("register test done");
  endtask
  task automatic t_reload();
    wr(`SBC_CF_ADDR, 8'h88);
    cyc(8);
    chk({6'h00, hi, lo}, 8'h03);
    @(posedge clk);
    split <= 1'b1;
    cyc(8);
    chk({6'h00, hi, lo}, 8'h02);
    @(posedge clk);
    b_scl <= 1'b1;
    cyc(8);
    chk({6'h00, hi, lo}, 8'h00);
    @(posedge clk);
    b_scl <= 1'b0;
    split <= 1'b0;
    wr(`SBC_CF_ADDR, 8'h00);
    $display("reload test done");
  endtask
  task automatic t_free();
    reset_dut();
    wr(`SBC_CF_ADDR, 8'h84);
    @(posedge clk);
    osel <= 2'h0;
    b_sda <= 1'b1;
    repeat (10) @(posedge clk);
    b_scl <= 1'b1;
    repeat (10) @(posedge clk);
    b_sda <= 1'b0;
    repeat (10) @(posedge clk);
    b_scl <= 1'b0;
    rd(`SBC_CF_ADDR);
    chk(d & 8'h20, 8'h20);
    rd(`SBC_CN_ADDR);
    chk(d & 8'h20, 8'h20);
    cyc(130);
    rd(`SBC_CF_ADDR);
    chk(d & 8'h20, 8'h20);
    poll(`SBC_CF_ADDR, 8'h20, 8'h00, 100);
    // stuck bus: software escapes by disabling and re-enabling
    @(posedge clk);
    b_sda <= 1'b1;
    repeat (10) @(posedge clk);
    b_scl <= 1'b1;
    cyc(10);
    rd(`SBC_CF_ADDR);
    chk(d & 8'h20, 8'h20);
    wr(`SBC_CF_ADDR, 8'h00);
    wr(`SBC_CF_ADDR, 8'h84);
    rd(`SBC_CF_ADDR);
    chk(d & 8'h20, 8'h00);
    @(posedge clk);
    b_sda <= 1'b0;
    repeat (4) @(posedge clk);
    b_scl <= 1'b0;
    $display("free timeout test done");
  endtask
  task automatic t_master();
    for (int s = 0; s < 4; s++) begin
      reset_dut();
      wr(`SBC_CF_ADDR, {6'h24, s[1:0]});
      @(posedge clk);
      osel <= s[1:0];
      wrong <= 1'b1;
      wr(`SBC_CN_ADDR, 8'h20);
      cyc(100);
      chk({7'h00, scl_oe}, 8'h00);
      @(posedge clk);
      wrong <= 1'b0;
      poll(`SBC_CN_ADDR, 8'h01, 8'h01, 100);
      chk(d, 8'hE1);
      chk({7'h00, scl_oe}, 8'h01);
    end
    // slow far side: it stretches every low phase
    @(posedge clk);
    tx_byte <= 8'hA4;
    stretch <= 1'b1;
    wr(`SBC_CN_ADDR, 8'h00);
    poll(`SBC_CN_ADDR, 8'h01, 8'h01, 1000);
    chk(d, 8'hC3);
    chk(pbyte, 8'hA4);
    @(posedge clk);
    stretch <= 1'b0;
    wr(`SBC_CN_ADDR, 8'h10);
    poll(`SBC_CF_ADDR, 8'h20, 8'h00, 300);
    rd(`SBC_CN_ADDR);
    chk(d & 8'hB1, 8'h00);
    chk({6'h00, scl, sda}, 8'h03);
    $display("master test done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_reload();
    t_free();
    t_master();
    end_of_test();
  end
endmodule
bind sbc_core sbc_core_sva i_sbc_core_sva (.clk(clk), .rst_b(rst_b),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
  .sfr_rdata_q(sfr_rdata_q), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe_q(scl_oe_q), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_q(sda_oe_q), .t0_ovf(t0_ovf), .t1_ovf(t1_ovf),
  .t2h_ovf(t2h_ovf), .t2l_ovf(t2l_ovf), .tmr3_split(tmr3_split),
  .tmr3_hi_reload_q(tmr3_hi_reload_q),
  .tmr3_lo_reload_q(tmr3_lo_reload_q), .tx_byte(tx_byte),
  .rx_byte_q(rx_byte_q), .addr_hit(addr_hit));
`default_nettype wire
